// >>> rtl/dsw_wakeup.sv
// Deep-sleep wake-up sequencer with an AHB-Lite register slave.
//
// Chosen here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module dsw_wakeup #(
  parameter int SLOT_TICKS = dsw_pkg::SLOT_TICKS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic low_power_clock,
  input wire logic core_clk_enabled,
  input wire logic radio_domain_up,
  output logic early_wake_irq,
  output logic sleep_exit_irq,
  output logic in_deep_sleep,
  output logic slot_tick,
  output logic irq
);
  // Pins from the power domain arrive asynchronously and are synchronised.
  logic [2:0] lp_sync;
  logic lp_last;
  logic [1:0] clk_sync;
  logic [1:0] rad_sync;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lp_sync <= 3'h0;
      clk_sync <= 2'h0;
      rad_sync <= 2'h0;
      lp_last <= 1'b0;
    end
    else
    begin
      lp_sync <= {lp_sync[1:0], low_power_clock};
      clk_sync <= {clk_sync[0], core_clk_enabled};
      rad_sync <= {rad_sync[0], radio_domain_up};
      lp_last <= lp_sync[2];
    end
  end
  wire lp_tick = lp_sync[2] & ~lp_last;
  wire core_up = clk_sync[1] & rad_sync[1];

  // Bus address phase capture.
  logic wr_pend;
  logic rd_pend;
  logic [7:0] a_addr;
  wire a_valid = hsel & hready & htrans[1];
  wire a_mapped = (haddr[31:8] == 24'h000000) & (haddr[1:0] == 2'h0);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      a_addr <= 8'h00;
    end
    else
    begin
      wr_pend <= a_valid & hwrite & a_mapped;
      rd_pend <= a_valid & ~hwrite & a_mapped;
      a_addr <= haddr[7:0];
    end
  end

  logic sleep_on;
  logic ext_req;
  logic ext_dis;
  logic [31:0] duration;
  logic [31:0] timing;
  logic [31:0] sleep_len;
  logic [dsw_pkg::IRQ_W-1:0] irq_status;
  logic [dsw_pkg::IRQ_W-1:0] irq_mask;
  dsw_pkg::dsw_state_t state;
  dsw_pkg::dsw_state_t next_state;
  logic [31:0] remain;
  logic [31:0] elapsed;
  logic [7:0] ext_cnt;
  logic ext_req_last;
  logic early_done;

  wire wr_ctrl = wr_pend & (a_addr == dsw_pkg::ADDR_CTRL);
  wire wr_dur = wr_pend & (a_addr == dsw_pkg::ADDR_DURATION);
  wire wr_tim = wr_pend & (a_addr == dsw_pkg::ADDR_TIMING);
  wire wr_mask = wr_pend & (a_addr == dsw_pkg::ADDR_IRQ_MASK);
  wire rd_stat = rd_pend & (a_addr == dsw_pkg::ADDR_IRQ_STATUS);
  wire [7:0] lead = timing[dsw_pkg::TIM_LEAD_LSB +: dsw_pkg::TIM_FIELD_W];
  wire [7:0] rel = timing[dsw_pkg::TIM_RELEASE_LSB +: dsw_pkg::TIM_FIELD_W];
  wire [7:0] ext_len = timing[dsw_pkg::TIM_EXT_LSB +: dsw_pkg::TIM_FIELD_W];
  // A raised request counts only while not disabled.
  wire ext_eff = ext_req & ~ext_dis;
  wire ext_rise = ext_eff & ~ext_req_last;
  wire in_sleep = (state == dsw_pkg::DSW_SLEEP);
  // Entry is refused while the request stands.
  wire enter = (state == dsw_pkg::DSW_ACTIVE) & sleep_on & ~ext_eff;
  wire expired = in_sleep & lp_tick & (remain <= 32'h1);
  // Lead and release compare against ticks still to go. A duration shorter
  // than the lead still raises the early interrupt once, on the first tick.
  wire lead_hit = in_sleep & lp_tick & ~early_done &
                  (remain <= {24'h0, lead} + 32'h1);
  wire rel_hit = in_sleep & lp_tick & (remain == {24'h0, rel} + 32'h1);
  wire ext_end = (state == dsw_pkg::DSW_EXT_WAKE) & lp_tick &
                 (ext_cnt + 8'h1 >= ext_len - rel);
  wire exit_now = (state == dsw_pkg::DSW_WAIT_UP) & core_up;

  always_comb
  begin
    next_state = state;
    unique case (state)
      dsw_pkg::DSW_ACTIVE:
        if (enter)
          next_state = dsw_pkg::DSW_SLEEP;
      dsw_pkg::DSW_SLEEP:
        if (ext_rise)
          next_state = dsw_pkg::DSW_EXT_WAKE;
        else if (expired)
          next_state = dsw_pkg::DSW_WAIT_UP;
      dsw_pkg::DSW_EXT_WAKE:
        if (ext_end)
          next_state = dsw_pkg::DSW_WAIT_UP;
      dsw_pkg::DSW_WAIT_UP:
        if (exit_now)
          next_state = dsw_pkg::DSW_ACTIVE;
      default:
        next_state = dsw_pkg::DSW_ACTIVE;
    endcase
  end

  // Status events; the set wins over the read-to-clear.
  wire early_set = (lead_hit & ~early_wake_irq) | (in_sleep & ext_rise);
  wire [1:0] ev = {exit_now, early_set};
  wire [1:0] next_status = (rd_stat ? 2'b00 : irq_status) | ev;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sleep_on <= 1'b0;
      ext_req <= 1'b0;
      ext_dis <= 1'b0;
      duration <= dsw_pkg::DURATION_RESET;
      timing <= dsw_pkg::TIMING_RESET;
      irq_mask <= 2'b00;
    end
    else
    begin
      if (wr_ctrl)
      begin
        sleep_on <= hwdata[dsw_pkg::CTRL_SLEEP_ON];
        ext_req <= hwdata[dsw_pkg::CTRL_EXT_WAKE_REQ];
        ext_dis <= hwdata[dsw_pkg::CTRL_EXT_WAKE_DIS];
      end
      else if (exit_now)
        sleep_on <= 1'b0;
      if (wr_dur)
        duration <= hwdata;
      if (wr_tim)
        timing <= hwdata;
      if (wr_mask)
        irq_mask <= hwdata[1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= dsw_pkg::DSW_ACTIVE;
      remain <= 32'h0;
      elapsed <= 32'h0;
      sleep_len <= 32'h0;
      ext_cnt <= 8'h00;
      ext_req_last <= 1'b0;
      irq_status <= 2'b00;
      early_done <= 1'b0;
    end
    else
    begin
      state <= next_state;
      ext_req_last <= ext_eff;
      irq_status <= next_status;
      if (enter)
        early_done <= 1'b0;
      else if (early_set)
        early_done <= 1'b1;
      if (enter)
      begin
        remain <= duration;
        elapsed <= 32'h0;
      end
      else if (lp_tick & (state != dsw_pkg::DSW_ACTIVE))
      begin
        elapsed <= elapsed + 32'h1;
        if (remain != 32'h0)
          remain <= remain - 32'h1;
      end
      // Length keeps growing while power-up is late.
      if (exit_now)
        sleep_len <= elapsed;
      if (in_sleep & ext_rise)
        ext_cnt <= 8'h00;
      else if (lp_tick)
        ext_cnt <= ext_cnt + 8'h1;
    end
  end

  // Outputs, all registered.
  logic [15:0] slot_cnt;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      early_wake_irq <= 1'b0;
      sleep_exit_irq <= 1'b0;
      in_deep_sleep <= 1'b0;
      slot_tick <= 1'b0;
      slot_cnt <= 16'h0000;
      irq <= 1'b0;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      if (early_set)
        early_wake_irq <= 1'b1;
      else if (rel_hit | ext_end | exit_now)
        early_wake_irq <= 1'b0;
      // Exit pulse follows the early interrupt by construction.
      sleep_exit_irq <= exit_now;
      in_deep_sleep <= (next_state != dsw_pkg::DSW_ACTIVE);
      slot_tick <= 1'b0;
      if (lp_tick)
      begin
        if (slot_cnt + 16'h1 >= SLOT_TICKS[15:0])
        begin
          slot_cnt <= 16'h0000;
          slot_tick <= 1'b1;
        end
        else
          slot_cnt <= slot_cnt + 16'h1;
      end
      irq <= |(next_status & irq_mask);
      hresp <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= 32'h0;
      if (a_valid & ~hwrite & a_mapped)
      begin
        unique case (haddr[7:0])
          dsw_pkg::ADDR_CTRL:
            hrdata <= {29'h0, ext_dis, ext_req, sleep_on};
          dsw_pkg::ADDR_DURATION:
            hrdata <= duration;
          dsw_pkg::ADDR_TIMING:
            hrdata <= timing;
          dsw_pkg::ADDR_SLEEP_LEN:
            hrdata <= sleep_len;
          dsw_pkg::ADDR_IRQ_STATUS:
            hrdata <= {30'h0, next_status};
          dsw_pkg::ADDR_IRQ_MASK:
            hrdata <= {30'h0, irq_mask};
          dsw_pkg::ADDR_STATE:
            hrdata <= {28'h0, state};
          default:
            hrdata <= 32'h0;
        endcase
      end
    end
  end

  a_exit_needs_up: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(sleep_exit_irq) |-> $past(core_up))
    else $error("sleep exit without core power");
  a_refuse_entry: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state == dsw_pkg::DSW_ACTIVE) && ext_eff |=>
    state == dsw_pkg::DSW_ACTIVE)
    else $error("sleep entered while wake request high");
  a_ext_early: assert property (
    @(posedge hclk) disable iff (!hresetn)
    in_sleep && ext_rise |=> early_wake_irq)
    else $error("external wake did not raise early interrupt");
  a_ext_disabled: assert property (
    @(posedge hclk) disable iff (!hresetn)
    in_sleep && ext_dis |=> state != dsw_pkg::DSW_EXT_WAKE)
    else $error("disabled external wake acted");
  a_wait_power: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state == dsw_pkg::DSW_WAIT_UP) && !core_up |=>
    state == dsw_pkg::DSW_WAIT_UP)
    else $error("left sleep before power up");
  a_len_latch: assert property (
    @(posedge hclk) disable iff (!hresetn)
    exit_now |=> sleep_len == $past(elapsed))
    else $error("sleep length not latched");
  a_exit_order: assert property (
    @(posedge hclk) disable iff (!hresetn)
    exit_now |-> early_done)
    else $error("exit before early interrupt");
  a_elapsed_run: assert property (
    @(posedge hclk) disable iff (!hresetn)
    lp_tick && in_sleep && !enter |=> elapsed == $past(elapsed) + 32'h1)
    else $error("sleep counter stalled");
  a_expiry_wait: assert property (
    @(posedge hclk) disable iff (!hresetn)
    expired && !ext_rise |=> state == dsw_pkg::DSW_WAIT_UP)
    else $error("expiry missed");
  c_timed_exit: cover property (@(posedge hclk) disable iff (!hresetn)
    expired ##[1:1000] exit_now);
  c_ext_exit: cover property (@(posedge hclk) disable iff (!hresetn)
    in_sleep && ext_rise ##[1:1000] exit_now);
  c_irq_out: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(irq));
endmodule

// >>> pkg/dsw_pkg.sv
// Register map, field layout and timing constants of the wake-up sequencer.
// How it works
// - Sleep ends only on duration expiry or on the external wake request.
// - Early wake interrupt rises a programmed lead count before expiry.
// - After expiry the sequencer waits in sleep until the core is powered.
// - Sleep length is reported; late power-up makes it exceed duration.
// - Exit and sleep-exit interrupt need expiry or the end of the external wake pulse, clocks enabled, radio up.
// - A rising external wake request during sleep raises the early wake interrupt at once.
// - External wake: early wake high time is the pulse-length field less the release field.
// - While the external wake request is high, sleep entry is refused.
// - With the disable bit set, the external wake request is ignored.
// - Lead and release are counted in low-power ticks before expiry.
// - Every exit gives early wake interrupt first, sleep-exit afterwards.
// - Slot reference keeps running from the low-power clock during sleep.
package dsw_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DURATION = 8'h04;
  localparam logic [7:0] ADDR_TIMING = 8'h08;
  localparam logic [7:0] ADDR_SLEEP_LEN = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam logic [7:0] ADDR_STATE = 8'h18;
  // Control word bits.
  localparam int CTRL_SLEEP_ON = 0;
  localparam int CTRL_EXT_WAKE_REQ = 1;
  localparam int CTRL_EXT_WAKE_DIS = 2;
  // Timing word fields: lead [7:0], release [15:8], pulse length [23:16].
  localparam int TIM_LEAD_LSB = 0;
  localparam int TIM_RELEASE_LSB = 8;
  localparam int TIM_EXT_LSB = 16;
  localparam int TIM_FIELD_W = 8;
  // Interrupt status bits.
  localparam int IRQ_EARLY = 0;
  localparam int IRQ_EXIT = 1;
  localparam int IRQ_W = 2;
  localparam logic [31:0] TIMING_RESET = 32'h0002_0001;
  localparam logic [31:0] DURATION_RESET = 32'h0000_0000;
  // Slot reference period in microseconds and its low-power tick count.
  localparam int SLOT_US = 625;
  localparam int LP_CLK_HZ = 32768;
  localparam int SLOT_TICKS = (SLOT_US * LP_CLK_HZ + 999999) / 1000000;
  typedef enum logic [3:0] {
    DSW_ACTIVE = 4'b0001,
    DSW_SLEEP = 4'b0010,
    DSW_EXT_WAKE = 4'b0100,
    DSW_WAIT_UP = 4'b1000
  } dsw_state_t;
endpackage

// >>> test/dsw_host_pm.sv
// Model of the host power manager facing the wake-up sequencer.
`timescale 1ns/1ps
module dsw_host_pm (
  output logic low_power_clock,
  output logic core_clk_enabled,
  output logic radio_domain_up,
  input wire logic early_wake_irq,
  input wire logic in_deep_sleep,
  input wire logic [7:0] up_delay
);
  // The low-power clock runs free and is unrelated to the bus clock.
  initial
  begin
    low_power_clock = 1'b0;
    forever #41 low_power_clock = ~low_power_clock;
  end
  // A large delay makes the power-up late and stretches the sleep.
  initial
  begin
    core_clk_enabled = 1'b1;
    radio_domain_up = 1'b1;
    forever
    begin
      @(posedge in_deep_sleep);
      core_clk_enabled <= 1'b0;
      radio_domain_up <= 1'b0;
      @(posedge early_wake_irq);
      repeat (up_delay) @(posedge low_power_clock);
      core_clk_enabled <= 1'b1;
      @(posedge low_power_clock);
      radio_domain_up <= 1'b1;
    end
  end
endmodule

// >>> test/dsw_wakeup_tb.sv
// Self-checking bench for the deep-sleep wake-up sequencer.
`timescale 1ns/1ps
module dsw_wakeup_tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic lpc, cke, rup, ewi, sxi, ids, slt, irq;
  logic [7:0] upd, lead;
  int fails, num_checks, i, n, slots;
  integer seed;
  dsw_wakeup #(.SLOT_TICKS(2)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .low_power_clock(lpc),
    .core_clk_enabled(cke), .radio_domain_up(rup), .early_wake_irq(ewi),
    .sleep_exit_irq(sxi), .in_deep_sleep(ids), .slot_tick(slt), .irq(irq));
  dsw_host_pm pm (.low_power_clock(lpc), .core_clk_enabled(cke),
    .radio_domain_up(rup), .early_wake_irq(ewi), .in_deep_sleep(ids),
    .up_delay(upd));
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  task automatic wrap_up();
    if (fails == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  // Every wait is bounded; running out ends the run as a failure.
  task automatic wt(ref logic s, input logic v, input int lim);
    for (int k = 0; k <= lim; k++)
    begin
      @(posedge hclk);
      slots += (slt === 1'b1);
      if (s === v)
        return;
    end
    fails++;
    wrap_up();
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    wt(hreadyout, 1'b1, 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wt(hreadyout, 1'b1, 50);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  function automatic logic [31:0] long_sleep(input logic [7:0] ld, up);
    return {31'h0, up > ld + 8'd6};
  endfunction
  // A low-power tick lasts at most eleven bus clocks in this bench.
  function automatic logic [31:0] ext_pulse_ok(input int cyc,
    input logic [7:0] len, rel);
    return {31'h0, cyc >= 1 && cyc <= int'(len - rel) * 11 + 1};
  endfunction
  task automatic timer_run(input logic [31:0] dur, input logic [7:0] ld, up,
    input logic [1:0] mk);
    logic lg;
    upd <= up;
    xfer(1'b1, dsw_pkg::ADDR_IRQ_MASK, {30'h0, mk});
    xfer(1'b1, dsw_pkg::ADDR_TIMING, {16'h0201, ld});
    xfer(1'b1, dsw_pkg::ADDR_DURATION, dur);
    xfer(1'b1, dsw_pkg::ADDR_CTRL, 32'h1);
    wt(ids, 1'b1, 20);
    wt(ewi, 1'b1, 20 * dur);
    repeat (2) @(posedge hclk);
    chk("irq", {31'h0, mk[0]}, {31'h0, irq});
    chk("asleep at early", 32'h1, {31'h0, ids});
    wt(sxi, 1'b1, 20 * (dur + up) + 200);
    chk("powered at exit", 32'h1, {31'h0, rup & cke});
    chk("early low at exit", 32'h0, {31'h0, ewi});
    wt(ids, 1'b0, 5);
    xfer(1'b0, dsw_pkg::ADDR_SLEEP_LEN, 32'h0);
    lg = rd > dur + 1;
    chk("long sleep", long_sleep(ld, up), {31'h0, lg});
    xfer(1'b0, dsw_pkg::ADDR_IRQ_STATUS, 32'h0);
    chk("status", 32'h3, rd);
    xfer(1'b0, dsw_pkg::ADDR_IRQ_STATUS, 32'h0);
    chk("status cleared", 32'h0, rd);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask
  initial
  begin
    seed = 32'h34D1;
    fails = 0;
    num_checks = 0;
    slots = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    upd = 8'h00;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, dsw_pkg::ADDR_TIMING, 32'h0);
    chk("timing reset", dsw_pkg::TIMING_RESET, rd);
    xfer(1'b0, dsw_pkg::ADDR_DURATION, 32'h0);
    chk("duration reset", dsw_pkg::DURATION_RESET, rd);
    xfer(1'b0, dsw_pkg::ADDR_STATE, 32'h0);
    chk("state", {28'h0, dsw_pkg::DSW_ACTIVE}, rd);
    xfer(1'b1, dsw_pkg::ADDR_SLEEP_LEN, 32'hFF);
    xfer(1'b0, dsw_pkg::ADDR_SLEEP_LEN, 32'h0);
    chk("length read only", 32'h0, rd);
    xfer(1'b0, 32'h100, 32'h0);
    chk("unmapped", 32'h0, rd);
    for (i = 0; i < 4; i++)
    begin
      lead = 8'h02 + 8'($random(seed) & 3);
      d = 32'd12 + 32'($random(seed) & 15);
      timer_run(d, lead, (i % 2) ? lead + 8'h0A : 8'h00,
        (i == 0) ? 2'b00 : 2'b11);
    end
    upd <= 8'h02;
    xfer(1'b1, dsw_pkg::ADDR_TIMING, 32'h0002_0104);
    xfer(1'b1, dsw_pkg::ADDR_DURATION, 32'd200);
    xfer(1'b1, dsw_pkg::ADDR_CTRL, 32'h1);
    wt(ids, 1'b1, 20);
    xfer(1'b1, dsw_pkg::ADDR_CTRL, 32'h3);
    wt(ewi, 1'b1, 4);
    for (n = 0; ewi === 1'b1 && n < 100; n++)
      @(posedge hclk);
    chk("ext pulse", 32'h1, ext_pulse_ok(n, 8'h02, 8'h01));
    wt(sxi, 1'b1, 400);
    chk("slot ticks", 32'h1, {31'h0, slots > 10});
    xfer(1'b0, dsw_pkg::ADDR_IRQ_STATUS, 32'h0);
    chk("ext status", 32'h3, rd);
    xfer(1'b1, dsw_pkg::ADDR_CTRL, 32'h3);
    repeat (30) @(posedge hclk);
    chk("entry refused", 32'h0, {31'h0, ids});
    xfer(1'b1, dsw_pkg::ADDR_CTRL, 32'h4);
    xfer(1'b1, dsw_pkg::ADDR_CTRL, 32'h5);
    wt(ids, 1'b1, 20);
    xfer(1'b1, dsw_pkg::ADDR_CTRL, 32'h7);
    repeat (20) @(posedge hclk);
    chk("ext ignored", 32'h0, {31'h0, ewi});
    wt(sxi, 1'b1, 3000);
    xfer(1'b1, dsw_pkg::ADDR_CTRL, 32'h0);
    wrap_up();
  end
endmodule
